/* hdl/dcrb_pkg.sv */
package dcrb_pkg;
  // record geometry
  localparam int REC_BYTES = 2048;
  localparam logic [10:0] REC_LAST_IDX = 11'h7ff;
  // field start offsets inside one 128-byte drive slot
  localparam logic [6:0] OFF_WS0 = 7'h40;
  localparam logic [6:0] OFF_PWR = 7'h50;
  localparam logic [6:0] OFF_PCA = 7'h5c;
  localparam logic [6:0] OFF_RUN = 7'h60;
  localparam logic [6:0] OFF_WS1 = 7'h6c;
  localparam logic [6:0] OFF_SUM = 7'h7c;
  localparam logic [6:0] OFF_PAD = 7'h7e;
  // modulation state limits and the unusable sum code
  localparam logic [2:0] STATE_MIN = 3'h1;
  localparam logic [2:0] STATE_MAX = 3'h4;
  localparam logic [10:0] SUM_ILLEGAL = 11'h400;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PCA = 8'h08;
  localparam logic [7:0] REG_SUM = 8'h0c;
  localparam logic [7:0] REG_WS0 = 8'h10;
  localparam logic [7:0] REG_WS1 = 8'h20;
  localparam logic [7:0] REG_RD_PCA = 8'h30;
  localparam logic [7:0] REG_RD_SUM = 8'h34;
  // control bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_SLOT = 1;
  localparam int CTRL_INCR = 3;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_SLOT = 2'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [10:0] idx;
    logic [7:0] data;
    logic last;
  } dcrb_byte_t;

  typedef struct packed {
    logic [10:0] init;
    logic [2:0] state;
    logic tbit;
  } dcrb_sum_t;
endpackage : dcrb_pkg

/* hdl/dcrb_builder.sv */
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
// Notes on behaviour
// [RL1] slot opens with 32-byte maker id, 16-byte serial, 16-byte model; undefined
// [RL2] layer-0 write strategy code, 16 bytes, sits at slot bytes 64 to 79
// [RL3] layer-1 write strategy code, 16 bytes, sits at slot bytes 108 to 123
// [RL4] power, time stamp, running calibration fields undefined; readers ignore them
// [RL5] bytes 92 to 95 hold start block address of last power calibration
// [RL6] reader treats an all-zero calibration address as absent
// [RL7] sum word at bytes 124 to 125 written in incremental mode; zero is invalid
// [RL8] sum word bits 15 to 5 hold signed initial sum, plus or minus 1023
// [RL9] sum word bits 4 to 2 hold next modulation state, only 1 to 4
// [RL10] sum word bit 1 is last channel bit, one space, zero mark
// [RL11] sum contents come from the linking sector second sync frame state
// [RL12] single drive uses first slot; unused slots and fields are zero; the code writes whichever slot CTRL bits 2 to 1 select, reset 0
// [RL13] sum bit 0, bytes 126 to 127 and bytes 512 upward are zero
// [RL14] multi-byte numbers are packed most significant byte first
module dcrb_builder
  import dcrb_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_sum_valid,
  input wire dcrb_sum_t link_sum,
  output dcrb_byte_t rec_out,
  output logic rec_out_valid,
  input wire logic rec_out_ready,
  input wire dcrb_byte_t rec_in,
  input wire logic rec_in_valid
);
  typedef enum logic [1:0] {DCRB_IDLE = 2'b01, DCRB_SEND = 2'b10} dcrb_state_t;

  dcrb_state_t st_reg, st_next;
  logic [10:0] cnt_reg, cnt_next;
  logic [7:0] byte_reg, byte_next;
  logic done_reg, done_next;
  logic [1:0] slot_reg, slot_next;
  logic incr_reg, incr_next;
  logic [31:0] pca_reg, pca_next;
  dcrb_sum_t sum_reg, sum_next;
  logic [31:0] ws0_reg [4];
  logic [31:0] ws0_next [4];
  logic [31:0] ws1_reg [4];
  logic [31:0] ws1_next [4];
  logic [31:0] rd_pca_reg, rd_pca_next;
  logic [15:0] rd_sum_reg, rd_sum_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire, start;
  logic [15:0] sum_word;
  logic rd_pca_ok, rd_sum_ok;
  logic [10:0] look_idx;
  logic [31:0] sum_mrg;

  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] b);
    unique case (b)
      2'h0: pick = w[31:24];
      2'h1: pick = w[23:16];
      2'h2: pick = w[15:8];
      default: pick = w[7:0];
    endcase
  endfunction : pick

  function automatic logic [31:0] merge(input logic [31:0] w, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = w;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        merge[8*i +: 8] = d[8*i +: 8];
    end
  endfunction : merge

  function automatic logic state_ok(input logic [2:0] s);
    state_ok = (s >= STATE_MIN) && (s <= STATE_MAX);
  endfunction : state_ok

  // sum word packing
  always_comb
  begin
    if (incr_reg && state_ok(sum_reg.state) && (sum_reg.init != SUM_ILLEGAL)) // RL7 RL9
      sum_word = {sum_reg.init, sum_reg.state, sum_reg.tbit, 1'b0}; // RL8 RL10 RL13
    else
      sum_word = 16'h0000; // RL7
  end

  // byte at a record index
  function automatic logic [7:0] rec_byte(input logic [10:0] idx, input logic [1:0] slot,
                                          input logic [31:0] pca, input logic [15:0] sw,
                                          input logic [31:0] w0 [4],
                                          input logic [31:0] w1 [4]);
    logic [6:0] off;
    logic [6:0] rel;
    off = idx[6:0];
    rel = off - OFF_WS1;
    rec_byte = 8'h00; // RL1 RL4 RL12 RL13
    if ((idx[10:9] == 2'h0) && (idx[8:7] == slot))
    begin
      if (off >= OFF_WS0 && off < OFF_PWR)
        rec_byte = pick(w0[off[3:2]], off[1:0]); // RL2 RL14
      else if (off >= OFF_PCA && off < OFF_RUN)
        rec_byte = pick(pca, off[1:0]); // RL5 RL14
      else if (off >= OFF_WS1 && off < OFF_SUM)
        rec_byte = pick(w1[rel[3:2]], rel[1:0]); // RL3 RL14
      else if (off >= OFF_SUM && off < OFF_PAD)
        rec_byte = off[0] ? sw[7:0] : sw[15:8]; // RL14
    end
  endfunction : rec_byte

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign start = wr_fire && (aw_addr_reg == REG_CTRL) && w_strb_reg[0]
    && w_data_reg[CTRL_START];

  // record emitter
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    look_idx = cnt_reg;
    unique case (st_reg)
      DCRB_IDLE:
      begin
        if (start)
        begin
          st_next = DCRB_SEND;
          cnt_next = 11'h000;
          look_idx = 11'h000;
          done_next = 1'b0;
        end
      end
      DCRB_SEND:
      begin
        if (rec_out_ready)
        begin
          if (cnt_reg == REC_LAST_IDX)
          begin
            st_next = DCRB_IDLE;
            done_next = 1'b1;
          end
          else
          begin
            cnt_next = cnt_reg + 11'h001;
            look_idx = cnt_reg + 11'h001;
          end
        end
      end
    endcase
    byte_next = rec_byte(look_idx, slot_reg, pca_reg, sum_word, ws0_reg, ws1_reg);
  end

  assign rec_out_valid = (st_reg == DCRB_SEND);
  assign rec_out.idx = cnt_reg;
  assign rec_out.data = byte_reg;
  assign rec_out.last = (cnt_reg == REC_LAST_IDX);

  // record reader
  always_comb
  begin
    rd_pca_next = rd_pca_reg;
    rd_sum_next = rd_sum_reg;
    if (rec_in_valid && (rec_in.idx[10:9] == 2'h0) && (rec_in.idx[8:7] == slot_reg))
    begin
      if (rec_in.idx[6:0] >= OFF_PCA && rec_in.idx[6:0] < OFF_RUN)
        rd_pca_next[8*(3-rec_in.idx[1:0]) +: 8] = rec_in.data; // RL14
      if (rec_in.idx[6:0] == OFF_SUM)
        rd_sum_next[15:8] = rec_in.data;
      if (rec_in.idx[6:0] == OFF_SUM + 7'h01)
        rd_sum_next[7:0] = rec_in.data;
    end
  end

  assign rd_pca_ok = (rd_pca_reg != 32'h0000_0000); // RL6
  assign rd_sum_ok = (rd_sum_reg != 16'h0000) && state_ok(rd_sum_reg[4:2]); // RL7 RL9

  // bus slave and registers
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    slot_next = slot_reg;
    incr_next = incr_reg;
    pca_next = pca_reg;
    sum_next = sum_reg;
    ws0_next = ws0_reg;
    ws1_next = ws1_reg;
    sum_mrg = merge({16'h0000, sum_reg, 1'b0}, w_data_reg, w_strb_reg);
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_next = 1'b0;
    if (wr_fire)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (aw_addr_reg == REG_CTRL)
      begin
        if (w_strb_reg[0])
        begin
          slot_next = w_data_reg[CTRL_SLOT +: 2]; // RL12
          incr_next = w_data_reg[CTRL_INCR];
        end
      end
      else if (aw_addr_reg == REG_PCA)
        pca_next = merge(pca_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == REG_SUM)
        sum_next = sum_mrg[15:1];
      else if (aw_addr_reg[7:4] == REG_WS0[7:4])
        ws0_next[aw_addr_reg[3:2]] = merge(ws0_reg[aw_addr_reg[3:2]], w_data_reg, w_strb_reg);
      else if (aw_addr_reg[7:4] == REG_WS1[7:4])
        ws1_next[aw_addr_reg[3:2]] = merge(ws1_reg[aw_addr_reg[3:2]], w_data_reg, w_strb_reg);
      else if (aw_addr_reg != REG_STATUS && aw_addr_reg != REG_RD_PCA
               && aw_addr_reg != REG_RD_SUM)
        bresp_next = RESP_SLVERR;
    end
    if (link_sum_valid)
      sum_next = link_sum; // RL11
    if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        REG_CTRL: rdata_next = {28'h0, incr_reg, slot_reg, 1'b0};
        REG_STATUS: rdata_next = {28'h0, rd_sum_ok, rd_pca_ok, done_reg, rec_out_valid};
        REG_PCA: rdata_next = pca_reg;
        REG_SUM: rdata_next = {16'h0000, sum_word};
        REG_RD_PCA: rdata_next = rd_pca_ok ? rd_pca_reg : 32'h0000_0000; // RL6
        REG_RD_SUM: rdata_next = {16'h0000, rd_sum_reg};
        default:
        begin
          if (s_axi_araddr[7:4] == REG_WS0[7:4])
            rdata_next = ws0_reg[s_axi_araddr[3:2]];
          else if (s_axi_araddr[7:4] == REG_WS1[7:4])
            rdata_next = ws1_reg[s_axi_araddr[3:2]];
          else
            rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= DCRB_IDLE;
      cnt_reg <= 11'h000;
      byte_reg <= 8'h00;
      done_reg <= 1'b0;
      slot_reg <= RST_SLOT;
      incr_reg <= 1'b0;
      pca_reg <= RST_WORD;
      sum_reg <= '0;
      ws0_reg <= '{default: RST_WORD};
      ws1_reg <= '{default: RST_WORD};
      rd_pca_reg <= RST_WORD;
      rd_sum_reg <= 16'h0000;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= RST_WORD;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= RST_WORD;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      byte_reg <= byte_next;
      done_reg <= done_next;
      slot_reg <= slot_next;
      incr_reg <= incr_next;
      pca_reg <= pca_next;
      sum_reg <= sum_next;
      ws0_reg <= ws0_next;
      ws1_reg <= ws1_next;
      rd_pca_reg <= rd_pca_next;
      rd_sum_reg <= rd_sum_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_high_zero: assert property (rec_out_valid && cnt_reg[10:9] != 2'h0 |-> byte_reg == 8'h00) // RL13
    else $error("record byte above 511 not zero");
  a_other_slot: assert property (rec_out_valid && cnt_reg[8:7] != slot_reg |-> byte_reg == 8'h00) // RL12
    else $error("unused slot byte not zero");
  a_pad_zero: assert property (rec_out_valid && cnt_reg[6:0] >= OFF_PAD |-> byte_reg == 8'h00) // RL13
    else $error("slot pad byte not zero");
  a_sum_low: assert property (rec_out_valid && cnt_reg[6:0] == OFF_SUM + 7'h01 |-> !byte_reg[0]) // RL13
    else $error("sum word bit 0 set");
  a_sum_state: assert property (sum_word != 16'h0000 |-> state_ok(sum_word[4:2]) && incr_reg) // RL9
    else $error("sum word carries bad state");
  a_pca_msb: assert property (rec_out_valid && cnt_reg[8:7] == slot_reg && cnt_reg[10:9] == 2'h0
    && cnt_reg[6:0] == OFF_PCA && $stable(pca_reg) |-> byte_reg == pca_reg[31:24]) // RL5
    else $error("calibration address not msb first");
  a_ws0_first: assert property (rec_out_valid && cnt_reg[8:7] == slot_reg && cnt_reg[10:9] == 2'h0
    && cnt_reg[6:0] == OFF_WS0 && $stable(ws0_reg[0]) |-> byte_reg == ws0_reg[0][31:24]) // RL2
    else $error("layer 0 strategy misplaced");
  a_ws1_first: assert property (rec_out_valid && cnt_reg[8:7] == slot_reg && cnt_reg[10:9] == 2'h0
    && cnt_reg[6:0] == OFF_WS1 && $stable(ws1_reg[0]) |-> byte_reg == ws1_reg[0][31:24]) // RL3
    else $error("layer 1 strategy misplaced");
  a_id_zero: assert property (rec_out_valid && cnt_reg[6:0] < OFF_WS0 |-> byte_reg == 8'h00) // RL1
    else $error("identity byte not zero");
  a_link_take: assert property (link_sum_valid |=> sum_reg == $past(link_sum)) // RL11
    else $error("link sum not captured");
  a_pca_zero: assert property (rd_pca_reg == 32'h0000_0000 |-> !rd_pca_ok) // RL6
    else $error("zero address reported present");
  a_walk_end: assert property (rec_out_valid && rec_out_ready && rec_out.last |=> !rec_out_valid
    && done_reg) // RL12
    else $error("record end not closed");
endmodule : dcrb_builder

/* verif/dcrb_drive_model.sv */
`timescale 1ns/1ns
module dcrb_drive_model
  import dcrb_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire dcrb_byte_t rec_out,
  input wire logic rec_out_valid,
  output logic rec_out_ready,
  output dcrb_byte_t rec_in,
  output logic rec_in_valid,
  input wire logic play,
  output logic busy,
  output int got,
  output logic bad
);
  logic [7:0] mem [REC_BYTES];
  logic [10:0] p;
  int seed = 52227;
  // sink with random stalls, then replays the record as a reading drive
  always @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      rec_out_ready <= 1'b0;
      rec_in <= '0;
      rec_in_valid <= 1'b0;
      busy <= 1'b0;
      got <= 0;
      bad <= 1'b0;
      p <= 11'h000;
    end
    else
    begin
      rec_out_ready <= ($random(seed) % 4) != 0;
      if (rec_out_valid && rec_out_ready)
      begin
        mem[rec_out.idx] <= rec_out.data;
        got <= (rec_out.idx == 11'h000) ? 1 : got + 1;
        if (rec_out.idx != 11'h000 && int'(rec_out.idx) != got)
          bad <= 1'b1;
        if (rec_out.last != (rec_out.idx == REC_LAST_IDX))
          bad <= 1'b1;
      end
      // idle data line toggles so a stale byte is never mistaken for a real one
      rec_in_valid <= busy;
      rec_in.data <= busy ? mem[p] : ~rec_in.data;
      rec_in.idx <= p;
      rec_in.last <= (p == REC_LAST_IDX);
      if (play && !busy)
      begin
        busy <= 1'b1;
        p <= 11'h000;
      end
      else if (busy)
      begin
        p <= p + 11'h001;
        if (p == REC_LAST_IDX)
          busy <= 1'b0;
      end
    end
endmodule : dcrb_drive_model

/* verif/tb.sv */
`timescale 1ns/1ns
module tb
  import dcrb_pkg::*;
;
  logic mclk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lsv, ovalid, oready, ivalid, play, pbusy, bad;
  logic [31:0] awaddr, wdata, araddr, rdata, pca, d;
  logic [31:0] ws0 [4];
  logic [31:0] ws1 [4];
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, slot;
  logic [15:0] sw;
  dcrb_sum_t lsum, lv;
  dcrb_byte_t obyte, ibyte;
  int got, fail_count, n_compared, t;
  int seed = 52227;

  dcrb_builder dut (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link_sum_valid(lsv), .link_sum(lsum), .rec_out(obyte),
    .rec_out_valid(ovalid), .rec_out_ready(oready), .rec_in(ibyte), .rec_in_valid(ivalid));

  dcrb_drive_model pm (.mclk(mclk), .arst_n(arst_n), .rec_out(obyte),
    .rec_out_valid(ovalid), .rec_out_ready(oready), .rec_in(ibyte),
    .rec_in_valid(ivalid), .play(play), .busy(pbusy), .got(got), .bad(bad));

  task automatic test_done;
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    int n;
    @(posedge mclk);
    awaddr <= {24'h0, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200)
      fail_count++;
    chk({30'h0, bresp}, {30'h0, e});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    @(posedge mclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200)
      fail_count++;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    chk(v, e);
  endtask : rc

  function automatic logic [15:0] sumw(input logic inc, input dcrb_sum_t s);
    if (inc && s.state >= STATE_MIN && s.state <= STATE_MAX && s.init != SUM_ILLEGAL)
      return {s.init, s.state, s.tbit, 1'b0};
    return 16'h0000;
  endfunction : sumw

  function automatic logic [7:0] eb(input int i);
    int o;
    o = i % 128;
    if (i >= 512 || i / 128 != slot)
      return 8'h00;
    if (o >= 64 && o < 80)
      return ws0[(o - 64) / 4][31 - 8 * (o % 4) -: 8];
    if (o >= 92 && o < 96)
      return pca[31 - 8 * (o % 4) -: 8];
    if (o >= 108 && o < 124)
      return ws1[(o - 108) / 4][31 - 8 * (o % 4) -: 8];
    if (o == 124)
      return sw[15:8];
    if (o == 125)
      return sw[7:0];
    return 8'h00;
  endfunction : eb

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    #640000;
    fail_count++;
    test_done;
  end

  initial
  begin
    arst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, lsv, play} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    lsum = '0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rc(REG_CTRL, 32'h0);
    rc(REG_STATUS, 32'h0);
    rc(REG_PCA, 32'h0);
    wr(8'hf0, 32'h1, RESP_SLVERR);
    rd(8'hf0, d);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    wstrb <= 4'h5;
    wr(REG_PCA, 32'hffff_ffff, RESP_OKAY);
    wstrb <= 4'hf;
    rc(REG_PCA, 32'h00ff_00ff);
    wr(REG_CTRL, 32'h0000_0008, RESP_OKAY);
    wr(REG_SUM, 32'h0000_246a, RESP_OKAY);
    wstrb <= 4'h2;
    wr(REG_SUM, 32'h0000_ff00, RESP_OKAY);
    wstrb <= 4'hf;
    rc(REG_SUM, 32'h0000_ff6a);
    for (int k = 0; k < 6; k++)
    begin
      slot = k[1:0];
      pca = (k == 1) ? 32'h0 : $random(seed);
      for (int j = 0; j < 4; j++)
      begin
        ws0[j] = $random(seed);
        ws1[j] = $random(seed);
        wr(REG_WS0 + 8'(4 * j), ws0[j], RESP_OKAY);
        wr(REG_WS1 + 8'(4 * j), ws1[j], RESP_OKAY);
      end
      lv.init = $random(seed);
      if (lv.init == SUM_ILLEGAL || k == 3)
        lv.init = (k == 3) ? SUM_ILLEGAL : 11'h000;
      if (k == 1)
        lv.init = 11'h401;
      lv.state = (k < 4) ? 3'(k + 1) : ((k == 4) ? 3'h0 : 3'h7);
      lv.tbit = $random(seed);
      wr(REG_PCA, pca, RESP_OKAY);
      wr(REG_SUM, {16'h0, lv, 1'b0}, RESP_OKAY);
      if (k == 0)
      begin
        lv.init = 11'h3ff;
        lv.tbit = ~lv.tbit;
        @(posedge mclk);
        lsum <= lv;
        lsv <= 1'b1;
        @(posedge mclk);
        lsv <= 1'b0;
      end
      sw = sumw(k != 2, lv);
      wr(REG_CTRL, {28'h0, k != 2, slot, 1'b0}, RESP_OKAY);
      rc(REG_SUM, {16'h0, sw});
      wr(REG_CTRL, {28'h0, k != 2, slot, 1'b1}, RESP_OKAY);
      if (k == 0)
        wr(REG_CTRL, {28'h0, 1'b1, slot, 1'b1}, RESP_OKAY);
      d = 32'h0;
      t = 0;
      while (!d[1] && t < 3000)
      begin
        rd(REG_STATUS, d);
        t++;
      end
      rc(REG_CTRL, {28'h0, k != 2, slot, 1'b0});
      chk(got, REC_BYTES);
      chk({31'h0, bad}, 32'h0);
      for (int i = 0; i < REC_BYTES; i++)
        chk(pm.mem[i], eb(i));
      @(posedge mclk);
      play <= 1'b1;
      @(posedge mclk);
      play <= 1'b0;
      t = 0;
      do
      begin
        @(posedge mclk);
        t++;
      end while (pbusy && t < 3000);
      rc(REG_RD_PCA, pca);
      rc(REG_RD_SUM, {16'h0, sw});
      rd(REG_STATUS, d);
      chk(d[3:2], {sw != 16'h0, pca != 32'h0});
    end
    test_done;
  end
endmodule : tb
